/* hdl/scanner_restart_interlock.sv */
// Behaviour
// RQ1: Object detected in safety zone switches the safe output pair off.
// RQ2: Restart mode is selectable between automatic and manual.
// RQ3: Automatic: outputs on after zone clear plus recovery time 200..60000 ms.
// RQ4: Manual: outputs stay off until object gone and valid button press.
// RQ5: Operator holds restart button 500 ms to 4.5 s for a valid press.
// RQ6: Outputs return on the release of a valid press, not its start.
// RQ7: Between stop and restart, track restart-allowed versus restart-blocked state.
// RQ8: Indicator LED lit while in restart-allowed interlock state.
// RQ9: Long press while object still present leaves device blocked, outputs off.
// RQ10: Scanning is cyclic, one rotation every 30 ms.
// RQ11: At least two scans needed before switch-off; 62 ms minimum response.
// RQ12: Scan count configurable; response 62 to 482 ms in 30 ms steps.
// RQ13: Response time adds 14 ms network latency only for a slave unit.
// RQ14: Reference point deviating beyond its tolerance switches outputs off.
// RQ15: At least 3 reference points per object, at most 15 in total.
// RQ16: Each point has near and far tolerance, each at least 10 mm.
// RQ17: Warn when vertical application uses more than 2 scans.
// RQ18: Capability limits range: 40 mm gives 3 m, 70 mm gives 5.5 m.
// RQ19: Too short or too long press ignored; outputs stay off.
// RQ20: New detection during recovery aborts it; timing restarts once clear.
`timescale 1ns/10ps
`default_nettype none
module scanner_restart_interlock #(
   parameter int msCycles = scanner_pkg::CYCLES_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Scan front end
   output logic scanStart,
   input wire logic zoneObject,
   input wire logic [15:0] objDistMm,
   input wire logic refMeasValid,
   input wire logic [3:0] refMeasIndex,
   input wire logic [15:0] refMeasDist,
   // Machine side
   input wire logic restartButton,
   output logic safeOutA,
   output logic safeOutB,
   output logic interlockLed
);
   import scanner_pkg::*;

   typedef struct packed {
      scanner_pkg::ilock_e ilock;
      logic outOn;
      logic [4:0] hits;
      logic [15:0] recTimer;
      logic manualMode;
      logic [4:0] scans;
      logic vertical;
      logic cap70;
      logic slaveRole;
      logic [15:0] recoveryMs;
      logic [3:0] pointCount;
      logic [3:0] objectCount;
      logic [3:0] refSel;
      logic [REF_POINTS-1:0][15:0] refDist;
      logic [REF_POINTS-1:0][15:0] tolNear;
      logic [REF_POINTS-1:0][15:0] tolFar;
      logic [REF_POINTS-1:0] pointFault;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } core_s;

   core_s st;
   core_s next_st;
   timing_if tim ();

   logic [15:0] maxRangeMm;
   logic [15:0] respMs;
   logic zoneStop;
   logic refFault;
   logic refCfgErr;
   logic scanWarn;
   logic stopNow;
   logic zoneClear;
   logic [31:0] ctrlWord;
   logic [31:0] statusWord;
   logic [31:0] selDist;
   logic [31:0] selTol;
   logic [31:0] wordNew;
   logic [31:0] readWord;
   logic readOk;
   logic writeOk;

   // Response ms from scan count and role
   function automatic logic [15:0] responseOf(input logic [4:0] scans, input logic slave);
      responseOf = 16'(RESP_MIN_MS + RESP_STEP_MS * (int'(scans) - SCANS_MIN) +
                       (slave ? NET_LATENCY_MS : 0));
   endfunction

   // Measurement outside the point's near/far band
   function automatic logic outOfTol(input logic [15:0] ref0, input logic [15:0] near,
                                     input logic [15:0] far, input logic [15:0] meas);
      outOfTol = ({1'b0, meas} + {1'b0, near} < {1'b0, ref0}) ||
                 ({1'b0, meas} > {1'b0, ref0} + {1'b0, far});
   endfunction

   scan_timebase #(
      .msCycles(msCycles)
   ) u_timebase (
      .clk_sys(clk_sys),
      .rst(rst),
      .tim(tim.base)
   );

   restart_press u_press (
      .clk_sys(clk_sys),
      .rst(rst),
      .restartButton(restartButton),
      .tim(tim.press)
   );

   // Derived configuration and stop causes
   assign maxRangeMm = st.cap70 ? 16'(RANGE_70_MM) : 16'(RANGE_40_MM); // see RQ18
   assign respMs = responseOf(st.scans, st.slaveRole); // see RQ11 see RQ12 see RQ13
   assign zoneStop = (st.hits >= st.scans); // see RQ11
   assign refFault = |st.pointFault; // see RQ14
   assign refCfgErr = (st.pointCount > 4'(REF_POINTS)) ||
                      ({4'h0, st.pointCount} < 8'(REF_PER_OBJECT) * {4'h0, st.objectCount}); // see RQ15
   assign scanWarn = st.vertical && (st.scans > 5'(VERT_SCANS_MAX)); // see RQ17
   // Bad point set is unsafe too
   assign stopNow = zoneStop || refFault || refCfgErr;
   // Clear needs one clean scan
   assign zoneClear = (st.hits == 5'h00) && !refFault && !refCfgErr;

   // Register images
   assign ctrlWord = {23'h000000, st.slaveRole, st.cap70, st.vertical, st.scans,
                      st.manualMode};
   assign statusWord = {25'h0000000, tim.pressLong, refCfgErr, scanWarn, refFault,
                        zoneStop, (st.ilock == ST_ARMED), st.outOn};
   assign selDist = (st.refSel < 4'(REF_POINTS)) ? {16'h0000, st.refDist[st.refSel]} : 32'h0;
   assign selTol = (st.refSel < 4'(REF_POINTS)) ?
                   {st.tolFar[st.refSel], st.tolNear[st.refSel]} : 32'h0;

   // Read decode; unmapped gives SLVERR
   always_comb begin
      readWord = 32'h00000000;
      readOk = 1'b1;
      case (araddr)
         OFS_CTRL: readWord = ctrlWord;
         OFS_RECOVERY: readWord = {16'h0000, st.recoveryMs};
         OFS_REFCFG: readWord = {24'h000000, st.objectCount, st.pointCount};
         OFS_REFSEL: readWord = {28'h0000000, st.refSel};
         OFS_REFDIST: readWord = selDist;
         OFS_REFTOL: readWord = selTol;
         OFS_STATUS: readWord = statusWord;
         OFS_TIMING: readWord = {maxRangeMm, respMs};
         default: readOk = 1'b0;
      endcase
   end

   // Held write data merged into register image
   always_comb begin
      wordNew = 32'h00000000;
      writeOk = 1'b1;
      case (st.awAddr)
         OFS_CTRL: wordNew = mergeStrb(ctrlWord, st.wData, st.wStrb);
         OFS_RECOVERY: wordNew = mergeStrb({16'h0000, st.recoveryMs}, st.wData, st.wStrb);
         OFS_REFCFG: wordNew = mergeStrb({24'h000000, st.objectCount, st.pointCount},
                                         st.wData, st.wStrb);
         OFS_REFSEL: wordNew = mergeStrb({28'h0000000, st.refSel}, st.wData, st.wStrb);
         OFS_REFDIST: wordNew = mergeStrb(selDist, st.wData, st.wStrb);
         OFS_REFTOL: wordNew = mergeStrb(selTol, st.wData, st.wStrb);
         OFS_STATUS: wordNew = 32'h00000000;
         OFS_TIMING: wordNew = 32'h00000000;
         default: writeOk = 1'b0;
      endcase
   end

   // Bus channels, scan counting, point checks and interlock
   always_comb begin
      next_st = st;
      // Address and data taken independently
      if (awvalid && !st.awHeld) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && !st.wHeld) begin
         next_st.wHeld = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      if (st.bValid && bready) begin
         next_st.bValid = 1'b0;
      end
      if (st.awHeld && st.wHeld && !st.bValid) begin
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp = writeOk ? RESP_OKAY : RESP_SLVERR;
         case (st.awAddr)
            OFS_CTRL: begin
               next_st.manualMode = wordNew[CTRL_MANUAL]; // see RQ2
               next_st.scans = 5'(clampU16({11'h000, wordNew[CTRL_SCANS_LSB +: 5]},
                                           16'(SCANS_MIN), 16'(SCANS_MAX))); // see RQ12
               next_st.vertical = wordNew[CTRL_VERTICAL];
               next_st.cap70 = wordNew[CTRL_CAP70];
               next_st.slaveRole = wordNew[CTRL_SLAVE];
            end
            OFS_RECOVERY: begin
               next_st.recoveryMs = clampU16(wordNew[15:0], 16'(RECOVERY_MIN_MS),
                                             16'(RECOVERY_MAX_MS)); // see RQ3
            end
            OFS_REFCFG: begin
               next_st.pointCount = wordNew[3:0];
               next_st.objectCount = wordNew[7:4];
            end
            OFS_REFSEL: next_st.refSel = wordNew[3:0];
            OFS_REFDIST: begin
               if (st.refSel < 4'(REF_POINTS)) begin
                  next_st.refDist[st.refSel] = wordNew[15:0];
               end
            end
            OFS_REFTOL: begin
               if (st.refSel < 4'(REF_POINTS)) begin
                  next_st.tolNear[st.refSel] = clampU16(wordNew[15:0], 16'(TOL_MIN_MM),
                                                        16'hFFFF); // see RQ16
                  next_st.tolFar[st.refSel] = clampU16(wordNew[31:16], 16'(TOL_MIN_MM),
                                                       16'hFFFF); // see RQ16
               end
            end
            default: ;
         endcase
      end
      // Read answers one cycle after address
      if (st.rValid && rready) begin
         next_st.rValid = 1'b0;
      end
      if (arvalid && !st.rValid) begin
         next_st.rValid = 1'b1;
         next_st.rData = readWord;
         next_st.rResp = readOk ? RESP_OKAY : RESP_SLVERR;
      end

      // Occupied scans in a row; objects past range not counted
      if (tim.scanTick) begin
         if (zoneObject && (objDistMm <= maxRangeMm)) begin // see RQ18
            if (st.hits != 5'(SCANS_MAX)) begin
               next_st.hits = st.hits + 5'h01; // see RQ11
            end
         end else begin
            next_st.hits = 5'h00;
         end
      end

      // Latest measurement sets each point's fault
      if (refMeasValid && refMeasIndex < st.pointCount && refMeasIndex < 4'(REF_POINTS)) begin
         next_st.pointFault[refMeasIndex] = outOfTol(st.refDist[refMeasIndex],
                                                     st.tolNear[refMeasIndex],
                                                     st.tolFar[refMeasIndex],
                                                     refMeasDist); // see RQ14 see RQ16
      end
      // Dropped points hold no fault
      for (int i = 0; i < REF_POINTS; i++) begin
         if (4'(i) >= st.pointCount) begin
            next_st.pointFault[i] = 1'b0;
         end
      end

      // Interlock: blocked, recovering, armed for button, running
      case (st.ilock)
         ST_RUN: begin
            if (stopNow) begin
               next_st.ilock = ST_BLOCKED; // see RQ1 see RQ14
            end
         end
         ST_BLOCKED: begin
            // Presses here are ignored
            if (zoneClear) begin // see RQ7 see RQ9
               next_st.ilock = st.manualMode ? ST_ARMED : ST_RECOVER; // see RQ2
               next_st.recTimer = 16'h0000;
            end
         end
         ST_RECOVER: begin
            if (!zoneClear) begin
               next_st.ilock = ST_BLOCKED; // see RQ20
            end else if (st.manualMode) begin
               next_st.ilock = ST_ARMED;
            end else if (st.recTimer >= st.recoveryMs) begin
               next_st.ilock = ST_RUN; // see RQ3
            end else if (tim.msTick) begin
               next_st.recTimer = st.recTimer + 16'h0001;
            end
         end
         ST_ARMED: begin
            if (!zoneClear) begin
               next_st.ilock = ST_BLOCKED; // see RQ7
            end else if (!st.manualMode) begin
               next_st.ilock = ST_RECOVER;
               next_st.recTimer = 16'h0000;
            end else if (tim.pressValid) begin
               next_st.ilock = ST_RUN; // see RQ4 see RQ6 see RQ19
            end
         end
         default: next_st.ilock = ST_BLOCKED;
      endcase
      // Outputs on only while running
      next_st.outOn = (next_st.ilock == ST_RUN) && !stopNow; // see RQ1
   end

   // Power-up starts blocked so the outputs never come on unchecked
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
         st.ilock <= ST_BLOCKED;
         st.scans <= SCANS_RST;
         st.recoveryMs <= RECOVERY_RST;
         for (int i = 0; i < REF_POINTS; i++) begin
            st.tolNear[i] <= 16'(TOL_MIN_MM);
            st.tolFar[i] <= 16'(TOL_MIN_MM);
         end
      end else begin
         st <= next_st;
      end
   end

   // Port drive
   assign awready = !st.awHeld;
   assign wready = !st.wHeld;
   assign bvalid = st.bValid;
   assign bresp = st.bResp;
   assign arready = !st.rValid;
   assign rvalid = st.rValid;
   assign rdata = st.rData;
   assign rresp = st.rResp;
   assign scanStart = tim.scanTick;
   assign safeOutA = st.outOn;
   assign safeOutB = st.outOn;
   assign interlockLed = (st.ilock == ST_ARMED); // see RQ8
endmodule // scanner_restart_interlock
`default_nettype wire

/* hdl/scanner_pkg.sv */
package scanner_pkg;
   // Time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int SCAN_PERIOD_MS = 30;
   // Response time and scan count
   localparam int RESP_MIN_MS = 62;
   localparam int RESP_MAX_MS = 482;
   localparam int RESP_STEP_MS = 30;
   localparam int SCANS_MIN = 2;
   localparam int SCANS_MAX = SCANS_MIN + (RESP_MAX_MS - RESP_MIN_MS) / RESP_STEP_MS;
   localparam int NET_LATENCY_MS = 14;
   localparam int VERT_SCANS_MAX = 2;
   // Restart timing
   localparam int RECOVERY_MIN_MS = 200;
   localparam int RECOVERY_MAX_MS = 60000;
   localparam int PRESS_MIN_MS = 500;
   localparam int PRESS_MAX_MS = 4500;
   // Reference points and detection range
   localparam int REF_POINTS = 15;
   localparam int REF_PER_OBJECT = 3;
   localparam int TOL_MIN_MM = 10;
   localparam int RANGE_40_MM = 3000;
   localparam int RANGE_70_MM = 5500;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RECOVERY = 8'h04;
   localparam logic [7:0] OFS_REFCFG = 8'h08;
   localparam logic [7:0] OFS_REFSEL = 8'h0C;
   localparam logic [7:0] OFS_REFDIST = 8'h10;
   localparam logic [7:0] OFS_REFTOL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_TIMING = 8'h1C;
   // CTRL field positions
   localparam int CTRL_MANUAL = 0;
   localparam int CTRL_SCANS_LSB = 1;
   localparam int CTRL_VERTICAL = 6;
   localparam int CTRL_CAP70 = 7;
   localparam int CTRL_SLAVE = 8;
   // STATUS field positions
   localparam int STS_OUT_ON = 0;
   localparam int STS_INTERLOCK_ON = 1;
   localparam int STS_ZONE_STOP = 2;
   localparam int STS_REF_FAULT = 3;
   localparam int STS_SCAN_WARN = 4;
   localparam int STS_REF_CFG_ERR = 5;
   localparam int STS_PRESS_LONG = 6;
   // Reset values and responses
   localparam logic [4:0] SCANS_RST = 5'h02;
   localparam logic [15:0] RECOVERY_RST = 16'h00C8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_BLOCKED, ST_RECOVER, ST_ARMED, ST_RUN} ilock_e;

   function automatic logic [15:0] clampU16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
      clampU16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = strb[i] ? wr[i*8 +: 8] : old[i*8 +: 8];
      end
      mergeStrb = old;
   endfunction
endpackage

/* hdl/timing_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface timing_if;
   logic msTick;
   logic scanTick;
   logic pressValid;
   logic pressLong;
   modport base (output msTick, output scanTick);
   modport press (input msTick, output pressValid, output pressLong);
   modport core (input msTick, input scanTick, input pressValid, input pressLong);
endinterface // timing_if
`default_nettype wire

/* hdl/scan_timebase.sv */
`timescale 1ns/10ps
`default_nettype none
module scan_timebase #(
   parameter int msCycles = scanner_pkg::CYCLES_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   timing_if.base tim
);
   import scanner_pkg::*;

   typedef struct packed {
      logic [15:0] cyc;
      logic [4:0] ms;
      logic msTick;
      logic scanTick;
   } tb_s;

   tb_s st;
   tb_s next_st;

   // Ms tick, scan tick per rotation
   always_comb begin
      next_st = st;
      next_st.msTick = 1'b0;
      next_st.scanTick = 1'b0;
      if (st.cyc == 16'(msCycles - 1)) begin
         next_st.cyc = 16'h0000;
         next_st.msTick = 1'b1;
         if (st.ms == 5'(SCAN_PERIOD_MS - 1)) begin // see RQ10
            next_st.ms = 5'h00;
            next_st.scanTick = 1'b1;
         end else begin
            next_st.ms = st.ms + 5'h01;
         end
      end else begin
         next_st.cyc = st.cyc + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tim.msTick = st.msTick;
   assign tim.scanTick = st.scanTick;
endmodule // scan_timebase
`default_nettype wire

/* hdl/restart_press.sv */
`timescale 1ns/10ps
`default_nettype none
module restart_press (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic restartButton,
   timing_if.press tim
);
   import scanner_pkg::*;

   typedef struct packed {
      logic [1:0] sync;
      logic held;
      logic [12:0] holdMs;
      logic valid;
      logic long;
   } press_s;

   press_s st;
   press_s next_st;

   // Hold time measured in ms; judged only at release
   always_comb begin
      next_st = st;
      next_st.sync = {st.sync[0], restartButton};
      next_st.held = st.sync[1];
      next_st.valid = 1'b0;
      if (st.sync[1]) begin
         // Saturate past the window; long presses stay invalid
         if (tim.msTick && st.holdMs <= 13'(PRESS_MAX_MS)) begin
            next_st.holdMs = st.holdMs + 13'h0001;
         end
      end else begin
         next_st.holdMs = 13'h0000;
      end
      if (st.held && !st.sync[1]) begin // see RQ6
         next_st.valid = (st.holdMs >= 13'(PRESS_MIN_MS)) &&
                         (st.holdMs <= 13'(PRESS_MAX_MS)); // see RQ5 see RQ19
      end
      next_st.long = st.sync[1] && (st.holdMs > 13'(PRESS_MIN_MS));
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tim.pressValid = st.valid;
   assign tim.pressLong = st.long;
endmodule // restart_press
`default_nettype wire

/* test/scanner_restart_interlock_props.sv */
`timescale 1ns/10ps
`default_nettype none
module scanner_restart_interlock_props #(
   parameter int msCycles = scanner_pkg::CYCLES_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scanStart,
   input wire logic refMeasValid,
   input wire logic restartButton,
   input wire logic safeOutA,
   input wire logic safeOutB,
   input wire logic interlockLed,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid
);
   import scanner_pkg::*;
   localparam int SCAN = SCAN_PERIOD_MS * msCycles;
   int scanCnt;
   logic scanSeen;
   logic [3:0] relCnt;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Cycles since scan start and since release
   always_ff @(posedge clk_sys) begin
      scanCnt <= (rst || scanStart) ? 0 : scanCnt + 1;
      scanSeen <= !rst && (scanSeen || scanStart);
      relCnt <= (rst || restartButton) ? 4'h0 : relCnt + {3'h0, relCnt != 4'hF};
   end
   AST_PAIR: assert property (safeOutA == safeOutB)
      else $error("pair split");
   AST_LED_OFF: assert property (interlockLed |-> !safeOutA)
      else $error("LED lit while on");
   AST_OFF_CAUSE: assert property ($fell(safeOutA) |-> $past(scanStart, 2) || $past(refMeasValid, 2))
      else $error("off without cause");
   AST_HOLD_OFF: assert property ($past(interlockLed) && restartButton |-> !safeOutA)
      else $error("on while held");
   AST_REL: assert property ($rose(safeOutA) && ($past(interlockLed) || $past(interlockLed, 2))
      |-> relCnt inside {[2:9]})
      else $error("restart not at release");
   AST_SCAN_PERIOD: assert property (scanStart && scanSeen |-> scanCnt == SCAN - 1)
      else $error("scan period wrong");
   AST_SCAN_GAP: assert property (scanSeen |-> scanCnt < SCAN)
      else $error("scan start missing");
   AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
endmodule // scanner_restart_interlock_props
bind scanner_restart_interlock scanner_restart_interlock_props #(.msCycles(msCycles)) props (
   .clk_sys, .rst, .scanStart, .refMeasValid, .restartButton, .safeOutA, .safeOutB,
   .interlockLed, .arvalid, .arready, .rvalid
);
`default_nettype wire

/* test/restart_operator.sv */
`timescale 1ns/10ps
`default_nettype none
module restart_operator #(
   parameter int msCycles = 4
) (
   input wire logic clk_sys,
   output logic restartButton
);
   // Open contact at start
   initial restartButton = 1'h0;
   // Quiet gap lets the synchroniser see each release
   task automatic press(input int ms);
      repeat (20) @(posedge clk_sys);
      restartButton <= 1'h1;
      repeat (ms * msCycles) @(posedge clk_sys);
      restartButton <= 1'h0;
   endtask
endmodule // restart_operator
`default_nettype wire

/* test/test_scanner_restart_interlock.sv */
`timescale 1ns/10ps
`default_nettype none
module test_scanner_restart_interlock;
   import scanner_pkg::*;
   localparam int MS = 4;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, scanStart, restartButton, safeOutA, safeOutB;
   logic interlockLed;
   logic [3:0] wstrb = 4'hF;
   logic zoneObject = 1'h0, refMeasValid = 1'h0;
   logic [15:0] objDistMm = 16'h03E8, refMeasDist = 16'h0000;
   logic [3:0] refMeasIndex = 4'h0;
   int errorCnt = 0, totalChecks = 0;
   always #25 clk_sys = ~clk_sys;
   scanner_restart_interlock #(.msCycles(MS)) dut (.clk_sys, .rst, .awaddr, .awprot(3'h0),
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .scanStart, .zoneObject, .objDistMm, .refMeasValid, .refMeasIndex, .refMeasDist,
      .restartButton, .safeOutA, .safeOutB, .interlockLed);
   restart_operator #(.msCycles(MS)) op (.clk_sys, .restartButton);
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic completeRun;
      $display("checks %0d errors %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Bus write, each channel released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rdReg(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   // Wait n scan starts
   task automatic scans(input int n);
      repeat (n) begin
         do @(posedge clk_sys); while (!scanStart);
      end
   endtask
   task automatic waitOn(output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (safeOutA !== 1'h1);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic meas(input logic [15:0] d);
      @(posedge clk_sys);
      refMeasDist <= d;
      refMeasValid <= 1'h1;
      @(posedge clk_sys);
      refMeasValid <= 1'h0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic testRegs;
      rdReg(OFS_CTRL);
      check(rd, {26'h0, SCANS_RST, 1'h0});
      wr(OFS_RECOVERY, 32'h0000_0064);
      rdReg(OFS_RECOVERY);
      check(rd, {16'h0, RECOVERY_RST});
      wr(OFS_RECOVERY, 32'h0000_EA61);
      rdReg(OFS_RECOVERY);
      check(rd, {16'h0, 16'(RECOVERY_MAX_MS)});
      wstrb <= 4'h2;
      wr(OFS_RECOVERY, 32'h0000_0100);
      wstrb <= 4'hF;
      rdReg(OFS_RECOVERY);
      check(rd, 32'h0000_0160);
      wr(OFS_RECOVERY, {16'h0, RECOVERY_RST});
      wr(8'h20, 32'h1);
      check(rs, RESP_SLVERR);
      rdReg(8'h20);
      check(rs, RESP_SLVERR);
      wr(OFS_STATUS, 32'hFF);
      check(rs, RESP_OKAY);
      $display("regs done");
   endtask
   // Stop, then recovery cut short
   task automatic testAuto;
      int n;
      zoneObject <= 1'h1;
      scans(1);
      settle;
      check(safeOutA, 1'h1);
      scans(1);
      settle;
      check(safeOutA, 1'h0);
      zoneObject <= 1'h0;
      scans(1);
      zoneObject <= 1'h1;
      scans(1);
      zoneObject <= 1'h0;
      scans(1);
      waitOn(n);
      check(n inside {[RECOVERY_MIN_MS * MS - 4:RECOVERY_MIN_MS * MS + 12]}, 1'h1);
      $display("auto done");
   endtask
   task automatic testScans;
      wr(OFS_CTRL, 32'h0000_01C8);
      rdReg(OFS_TIMING);
      check(rd, {16'(RANGE_70_MM), 16'(RESP_MIN_MS + 2 * RESP_STEP_MS + NET_LATENCY_MS)});
      rdReg(OFS_STATUS);
      check(rd[STS_SCAN_WARN], 1'h1);
      objDistMm <= 16'h0FA0;
      zoneObject <= 1'h1;
      scans(3);
      settle;
      check(safeOutA, 1'h1);
      scans(1);
      settle;
      check(safeOutA, 1'h0);
      $display("scans done");
   endtask
   task automatic testManual;
      objDistMm <= 16'h03E8;
      wr(OFS_CTRL, 32'h0000_0005);
      op.press(600);
      repeat (10) @(posedge clk_sys);
      check({safeOutA, interlockLed}, 2'h0);
      zoneObject <= 1'h0;
      scans(1);
      settle;
      check(interlockLed, 1'h1);
      rdReg(OFS_STATUS);
      check(rd[STS_INTERLOCK_ON], 1'h1);
      op.press(300);
      op.press(5000);
      repeat (10) @(posedge clk_sys);
      check(safeOutA, 1'h0);
      op.press(600);
      check(safeOutA, 1'h0);
      repeat (10) @(posedge clk_sys);
      check({safeOutA, interlockLed}, 2'h2);
      $display("manual done");
   endtask
   task automatic testRef;
      wr(OFS_REFCFG, 32'h0000_0013);
      wr(OFS_REFSEL, 32'h0);
      wr(OFS_REFDIST, 32'h0000_03E8);
      wr(OFS_REFTOL, 32'h0005_0005);
      rdReg(OFS_REFTOL);
      check(rd, {16'(TOL_MIN_MM), 16'(TOL_MIN_MM)});
      meas(16'h03F2);
      check(safeOutA, 1'h1);
      refMeasIndex <= 4'h3;
      meas(16'h0FFF);
      check(safeOutA, 1'h1);
      refMeasIndex <= 4'h0;
      meas(16'h03F3);
      check(safeOutA, 1'h0);
      wr(OFS_REFCFG, 32'h0000_0012);
      rdReg(OFS_STATUS);
      check(rd[STS_REF_CFG_ERR], 1'h1);
      $display("ref done");
   endtask
   // Main sequence
   initial begin
      int n;
      repeat (4) @(posedge clk_sys);
      rst <= 1'h0;
      waitOn(n);
      testRegs;
      testAuto;
      testScans;
      testManual;
      testRef;
      completeRun;
   end
   // Watchdog
   initial begin
      #(80000 * 50);
      errorCnt++;
      completeRun;
   end
endmodule // test_scanner_restart_interlock
`default_nettype wire
